//--- drc_defines.svh
// Constants for the DRAM controller: timing counts, field positions, reset values
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

// ----------------------------------------
// Clock and refresh timing
// ----------------------------------------
`define DRC_CLK_PERIOD_NS 8
`define DRC_REF_BASE_PERIOD_NS 40
`define DRC_REF_TICK_CYCLES (`DRC_REF_BASE_PERIOD_NS / `DRC_CLK_PERIOD_NS)
`define DRC_REF_INTERVAL_NS 9600
`define DRC_REF_RELOAD 8'h0f
`define DRC_REF_TERMINAL 8'hff
`define DRC_TICK_RESET 3'h0

// ----------------------------------------
// Access sequencing, in master counter steps
// ----------------------------------------
`define DRC_T_COL 4'h1
`define DRC_T_CAS 4'h2
`define DRC_T_ACK_END 4'h3
`define DRC_T_RD_END 4'h4
`define DRC_T_WR_CAS 4'h1
`define DRC_T_WR_END 4'h2
`define DRC_T_REF_RAS 4'h1
`define DRC_T_REF_END 4'h3
`define DRC_T_PRECHARGE_LAST 4'h1
`define DRC_CNT_RESET 4'h0

// ----------------------------------------
// Address fields, word address bits 22..2
// ----------------------------------------
`define DRC_SPACE_BIT 20
`define DRC_BANK_HI 19
`define DRC_BANK_LO 18
`define DRC_ROW_HI 17
`define DRC_ROW_LO 9
`define DRC_COL_HI 8
`define DRC_COL_LO 0

// ----------------------------------------
// Idle levels of the active-low strobes, and read buffer depth
// ----------------------------------------
`define DRC_STROBES_OFF 4'hf
`define DRC_FIFO_DEPTH 16

`endif

//--- drc_pkg.sv
// Types shared by the DRAM controller modules
package drc_pkg;

   typedef enum logic [2:0] {
      DRC_RESET_WAIT,
      DRC_REFRESH,
      DRC_PRECHARGE,
      DRC_IDLE,
      DRC_READ,
      DRC_WRITE,
      DRC_IDLE_RAS
   } drc_state_e;

   // Processor request pins, all active low except the address
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic same_page_hint_n;
      logic [3:0] lane_enable_n;
      logic [20:0] addr;
   } drc_req_s;

   // Transceiver controls
   typedef struct packed {
      logic latch_a_to_b;
      logic [3:0] drive_a_to_b_n;
      logic latch_b_to_a;
      logic chip_sel_b_to_a_n;
   } drc_xcvr_s;

endpackage : drc_pkg

//--- drc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module drc_fifo
   import drc_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Fill side
   input wire logic s_valid_in,
   output logic s_ready_out,
   input wire logic [WIDTH-1:0] s_data_in,
   // Drain side
   output logic m_valid_out,
   input wire logic m_ready_in,
   output logic [WIDTH-1:0] m_data_out
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } drc_fifo_s;

   logic [WIDTH-1:0] mem [DEPTH];
   drc_fifo_s f_reg;
   drc_fifo_s f_next;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (f_reg.wp[AW] != f_reg.rp[AW]) && (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]);
   assign empty = (f_reg.wp == f_reg.rp);
   assign s_ready_out = !full;
   assign m_valid_out = !empty;
   assign m_data_out = mem[f_reg.rp[AW-1:0]];
   assign push = s_valid_in && !full;
   assign pop = m_ready_in && !empty;

   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.wp = f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = f_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   // Storage has no reset; only the pointers say what is valid
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[f_reg.wp[AW-1:0]] <= s_data_in;
      end
   end

endmodule : drc_fifo

//--- drc_ctrl.sv
// DRAM controller: control sequencing, refresh timer, byte lanes, address mux, transceivers
//
// Contract
// RULE1 - Refresh timer reloads 0x0f, pulses at 0xff
// RULE2 - Refresh interval 9.6 us bounds RAS low
// RULE3 - Idle row held: RAS low, CAS off
// RULE4 - Lane strobe is lane enable OR write
// RULE5 - Lane strobes active before CAS falls
// RULE6 - Address mux settles one cycle before strobe
// RULE7 - Four RAS/CAS pairs, bank from A21:A20
// RULE8 - Write keeps latch open, lanes gate drivers
// RULE9 - Read latch captures as CAS removed
// RULE10 - Direction set DRAM toward bus on reads
// RULE11 - Processor gate drives bus, releases early
// RULE12 - Cycle active flags every DRAM access
// RULE13 - Cycle active stage on system clock
// RULE14 - Acknowledge and read complete end access
// RULE15 - Row held flag while RAS left low
// RULE16 - Four-bit master counter times all events
// RULE17 - Reset and refresh activity indications
// RULE18 - Idle arbitrates refresh against A22-low access
// RULE19 - Reset resyncs, refreshes once, then idles
// RULE20 - Writes end idle with RAS held
// RULE21 - Refresh request held until acknowledged
`timescale 1ns/1ns
`include "drc_defines.svh"
module drc_ctrl
   import drc_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int FIFO_DEPTH = `DRC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // Processor request pins
   input wire drc_req_s cpu_req_in,
   input wire logic cpu_output_gate_n_in,
   // Processor responses
   output logic ack_n_out,
   output logic read_complete_enable_n_out,
   // Read data toward the processor side
   output logic [DATA_W-1:0] rd_data_out,
   output logic rd_data_valid_out,
   input wire logic rd_data_ready_in,
   // DRAM side
   input wire logic [DATA_W-1:0] dram_data_in,
   output logic [3:0] ras_n_out,
   output logic [3:0] cas_n_out,
   output logic mux_col_sel_out,
   output logic [8:0] dram_addr_out,
   output logic [3:0] lane_write_strobe_n_out,
   // Transceiver controls
   output drc_xcvr_s xcvr_out,
   output logic drive_b_to_a_n_out,
   // Status
   output logic cycle_active_out,
   output logic cycle_active_delayed_out,
   output logic row_held_flag_out,
   output logic reset_active_out,
   output logic refresh_ack_out,
   output logic refresh_req_out
);

   localparam logic [2:0] TICK_LAST = 3'(`DRC_REF_TICK_CYCLES - 1);

   typedef struct packed {
      drc_req_s s1;
      drc_req_s s2;
      logic [DATA_W-1:0] d1;
      logic [DATA_W-1:0] d2;
      drc_state_e st;
      logic [3:0] cnt;
      logic [1:0] bank;
      logic [3:0] ras_n;
      logic [3:0] cas_n;
      logic mux_col;
      logic [8:0] addr;
      logic ack_n;
      logic rdcen_n;
      logic cyc;
      logic cyc_d;
      logic row_held;
      logic rle;
      logic rst_act;
      logic ref_ack;
      logic dram_wr;
      logic [3:0] wstb_n;
      logic tr_n;
      logic armed;
      logic ref_pend;
      logic [2:0] tick;
      logic [7:0] rtimer;
      logic ref_req;
      logic push;
      logic [DATA_W-1:0] rdata;
   } drc_ctrl_s;

   drc_ctrl_s r_reg;
   drc_ctrl_s r_next;
   logic fifo_ready;
   logic rd;
   logic wr;
   logic in_dram;
   logic near;
   logic cnt_gate;

   // ----------------------------------------
   // Read data buffer
   // ----------------------------------------
   drc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(ref_clk_in),
      .reset_in(reset_in),
      .s_valid_in(r_reg.push),
      .s_ready_out(fifo_ready),
      .s_data_in(r_reg.rdata),
      .m_valid_out(rd_data_valid_out),
      .m_ready_in(rd_data_ready_in),
      .m_data_out(rd_data_out)
   );

   // ----------------------------------------
   // Decoded request, from the second sync stage only
   // ----------------------------------------
   assign rd = !r_reg.s2.rd_n;
   assign wr = !r_reg.s2.wr_n;
   assign in_dram = !r_reg.s2.addr[`DRC_SPACE_BIT]; // [RULE18]
   assign near = !r_reg.s2.same_page_hint_n;
   // Counter runs only while a sequence is in flight
   assign cnt_gate = r_reg.cyc_d || r_reg.cyc || r_reg.ref_ack || (r_reg.st == DRC_PRECHARGE); // [RULE16]

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.s1 = cpu_req_in;
      r_next.s2 = r_reg.s1;
      r_next.d1 = dram_data_in;
      r_next.d2 = r_reg.d1;
      r_next.cyc_d = r_reg.cyc; // [RULE13]
      r_next.push = 1'b0;
      r_next.rle = 1'b0;
      r_next.ref_req = 1'b0;
      r_next.cnt = cnt_gate ? r_reg.cnt + 4'h1 : `DRC_CNT_RESET; // [RULE16]
      if (!rd && !wr) begin
         r_next.armed = 1'b1;
      end

      // Refresh timer: prescaled to the 25 MHz base so 240 steps span 9.6 us
      if (r_reg.tick == TICK_LAST) begin
         r_next.tick = `DRC_TICK_RESET;
         r_next.rtimer = r_reg.rtimer + 8'h01; // [RULE1]
         if (r_reg.rtimer == `DRC_REF_TERMINAL) begin
            r_next.ref_req = 1'b1; // [RULE1] [RULE2]
         end
      end else begin
         r_next.tick = r_reg.tick + 3'h1;
      end

      unique case (r_reg.st)
         DRC_RESET_WAIT: begin
            // Hold off until the processor shows no strobe, then refresh once
            r_next.rst_act = 1'b1; // [RULE17]
            if (!rd && !wr) begin
               r_next.st = DRC_REFRESH; // [RULE19]
               r_next.ref_ack = 1'b1;
               r_next.ref_pend = 1'b0;
               r_next.cnt = `DRC_CNT_RESET;
            end
         end
         DRC_IDLE: begin
            if (r_reg.ref_pend) begin
               r_next.st = DRC_REFRESH; // [RULE18]
               r_next.ref_ack = 1'b1; // [RULE17]
               r_next.ref_pend = 1'b0; // [RULE21]
               r_next.cnt = `DRC_CNT_RESET;
            end else if (r_reg.armed && in_dram && (wr || (rd && fifo_ready))
                         && (r_reg.addr == r_reg.s2.addr[`DRC_ROW_HI:`DRC_ROW_LO])) begin // [RULE6]
               // Reads wait for buffer room; the row must already stand a cycle before RAS
               r_next.bank = r_reg.s2.addr[`DRC_BANK_HI:`DRC_BANK_LO]; // [RULE7]
               r_next.ras_n = ~(4'h1 << r_reg.s2.addr[`DRC_BANK_HI:`DRC_BANK_LO]); // [RULE7]
               r_next.cyc = 1'b1; // [RULE12] [RULE13]
               r_next.armed = 1'b0;
               r_next.cnt = `DRC_CNT_RESET;
               r_next.dram_wr = wr;
               r_next.wstb_n = r_reg.s2.lane_enable_n | {4{!wr}}; // [RULE4] [RULE5]
               r_next.tr_n = !rd; // [RULE10]
               r_next.st = wr ? DRC_WRITE : DRC_READ;
            end
         end
         DRC_READ: begin
            if (r_reg.cnt == `DRC_T_COL) begin
               r_next.mux_col = 1'b1; // [RULE6]
            end
            if (r_reg.cnt == `DRC_T_CAS) begin
               r_next.cas_n = ~(4'h1 << r_reg.bank); // [RULE7]
               r_next.ack_n = 1'b0; // [RULE14]
               r_next.rdcen_n = 1'b0; // [RULE14]
            end
            if (r_reg.cnt == `DRC_T_ACK_END) begin
               r_next.ack_n = 1'b1;
               r_next.rdcen_n = 1'b1;
            end
            if (r_reg.cnt == `DRC_T_RD_END) begin
               // Data is caught in the same edge that lifts CAS
               r_next.cas_n = `DRC_STROBES_OFF; // [RULE9]
               r_next.rle = 1'b1; // [RULE9]
               r_next.ras_n = `DRC_STROBES_OFF;
               r_next.cyc = 1'b0; // [RULE12]
               r_next.mux_col = 1'b0;
               r_next.tr_n = 1'b1; // [RULE10]
               r_next.st = DRC_PRECHARGE;
               r_next.cnt = `DRC_CNT_RESET;
            end
         end
         DRC_WRITE: begin
            // Page writes enter at the CAS step with the column already set
            if (r_reg.cnt == `DRC_CNT_RESET) begin
               r_next.ack_n = 1'b0; // [RULE14]
               r_next.mux_col = 1'b1; // [RULE6]
            end
            if (r_reg.cnt == `DRC_T_WR_CAS) begin
               r_next.ack_n = 1'b1;
               r_next.cas_n = ~(4'h1 << r_reg.bank); // [RULE5] [RULE7]
            end
            if (r_reg.cnt == `DRC_T_WR_END) begin
               r_next.cas_n = `DRC_STROBES_OFF;
               r_next.cyc = 1'b0; // [RULE12]
               r_next.dram_wr = 1'b0;
               r_next.wstb_n = `DRC_STROBES_OFF; // [RULE4]
               r_next.mux_col = 1'b0;
               r_next.row_held = 1'b1; // [RULE15]
               r_next.st = DRC_IDLE_RAS; // [RULE20]
            end
         end
         DRC_IDLE_RAS: begin
            r_next.cas_n = `DRC_STROBES_OFF; // [RULE3]
            if (r_reg.ref_pend || (r_reg.armed && in_dram && (rd || (wr && !near)))) begin
               // Refresh lifts RAS here, which bounds the held row time
               r_next.ras_n = `DRC_STROBES_OFF; // [RULE2]
               r_next.st = DRC_PRECHARGE;
               r_next.cnt = `DRC_CNT_RESET;
            end else if (r_reg.armed && in_dram && wr && near) begin
               r_next.cyc = 1'b1; // [RULE12]
               r_next.ack_n = 1'b0; // [RULE14]
               r_next.mux_col = 1'b1; // [RULE6]
               r_next.dram_wr = 1'b1;
               r_next.wstb_n = r_reg.s2.lane_enable_n; // [RULE4] [RULE5]
               r_next.armed = 1'b0;
               r_next.cnt = `DRC_T_WR_CAS;
               r_next.st = DRC_WRITE;
            end else if (r_reg.armed && !in_dram && (rd || wr)) begin
               // An outside access breaks the page, so drop the row at once
               r_next.ras_n = `DRC_STROBES_OFF;
               r_next.row_held = 1'b0; // [RULE15]
               r_next.st = DRC_IDLE;
            end
         end
         DRC_REFRESH: begin
            // CAS ahead of RAS on every bank
            r_next.cas_n = 4'h0;
            if (r_reg.cnt == `DRC_T_REF_RAS) begin
               r_next.ras_n = 4'h0;
            end
            if (r_reg.cnt == `DRC_T_REF_END) begin
               r_next.ras_n = `DRC_STROBES_OFF;
               r_next.cas_n = `DRC_STROBES_OFF;
               r_next.ref_ack = 1'b0; // [RULE17]
               r_next.rtimer = `DRC_REF_RELOAD; // [RULE1]
               r_next.tick = `DRC_TICK_RESET;
               r_next.st = DRC_PRECHARGE;
               r_next.cnt = `DRC_CNT_RESET;
            end
         end
         DRC_PRECHARGE: begin
            // The word sampled while CAS was low leaves the second sync stage only now
            if (r_reg.rle) begin
               r_next.rdata = r_reg.d2; // [RULE9]
               r_next.push = 1'b1;
            end
            if (r_reg.cnt == `DRC_T_PRECHARGE_LAST) begin
               r_next.row_held = 1'b0; // [RULE15]
               r_next.rst_act = 1'b0; // [RULE19]
               r_next.st = DRC_IDLE;
            end
         end
      endcase

      // Row/column mux: the address register follows the select, one cycle ahead of the strobe
      r_next.addr = r_next.mux_col ? r_reg.s2.addr[`DRC_COL_HI:`DRC_COL_LO]
                                   : r_reg.s2.addr[`DRC_ROW_HI:`DRC_ROW_LO]; // [RULE6]

      // A new request in the same cycle as the clear still stays pending
      if (r_reg.ref_req) begin
         r_next.ref_pend = 1'b1; // [RULE21]
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         r_reg <= '{
            s1: '1,
            s2: '1,
            d1: '0,
            d2: '0,
            st: DRC_RESET_WAIT,
            cnt: `DRC_CNT_RESET,
            bank: 2'h0,
            ras_n: `DRC_STROBES_OFF,
            cas_n: `DRC_STROBES_OFF,
            mux_col: 1'b0,
            addr: 9'h000,
            ack_n: 1'b1,
            rdcen_n: 1'b1,
            cyc: 1'b0,
            cyc_d: 1'b0,
            row_held: 1'b0,
            rle: 1'b0,
            rst_act: 1'b1,
            ref_ack: 1'b0,
            dram_wr: 1'b0,
            wstb_n: `DRC_STROBES_OFF,
            tr_n: 1'b1,
            armed: 1'b0,
            ref_pend: 1'b0,
            tick: `DRC_TICK_RESET,
            rtimer: `DRC_REF_RELOAD,
            ref_req: 1'b0,
            push: 1'b0,
            rdata: '0
         };
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ras_n_out = r_reg.ras_n;
   assign cas_n_out = r_reg.cas_n;
   assign mux_col_sel_out = r_reg.mux_col;
   assign dram_addr_out = r_reg.addr;
   assign ack_n_out = r_reg.ack_n;
   assign read_complete_enable_n_out = r_reg.rdcen_n;
   assign lane_write_strobe_n_out = r_reg.wstb_n;
   assign xcvr_out.latch_a_to_b = r_reg.dram_wr; // [RULE8]
   assign xcvr_out.drive_a_to_b_n = r_reg.wstb_n; // [RULE8]
   assign xcvr_out.latch_b_to_a = r_reg.rle; // [RULE9]
   assign xcvr_out.chip_sel_b_to_a_n = r_reg.tr_n; // [RULE10]
   // Bus drive timing belongs to the processor; passed straight through
   assign drive_b_to_a_n_out = cpu_output_gate_n_in; // [RULE11]
   assign cycle_active_out = r_reg.cyc;
   assign cycle_active_delayed_out = r_reg.cyc_d;
   assign row_held_flag_out = r_reg.row_held;
   assign reset_active_out = r_reg.rst_act;
   assign refresh_ack_out = r_reg.ref_ack;
   assign refresh_req_out = r_reg.ref_req;

endmodule : drc_ctrl

//--- drc_ctrl_checker.sv
// Port-level assertions for the DRAM controller
`timescale 1ns/1ns
module drc_ctrl_checker
   import drc_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic ack_n_out,
   input wire logic read_complete_enable_n_out,
   input wire logic [3:0] ras_n_out,
   input wire logic [3:0] cas_n_out,
   input wire logic mux_col_sel_out,
   input wire logic [8:0] dram_addr_out,
   input wire logic [3:0] lane_write_strobe_n_out,
   input wire drc_xcvr_s xcvr_out,
   input wire logic cycle_active_out,
   input wire logic cycle_active_delayed_out,
   input wire logic row_held_flag_out,
   input wire logic refresh_ack_out,
   input wire logic refresh_req_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   a_lane_write_only: assert property ((lane_write_strobe_n_out != 4'hf) |-> xcvr_out.latch_a_to_b)
      else $error("lane strobe outside a write");
   a_lane_gates_drv: assert property (xcvr_out.drive_a_to_b_n == lane_write_strobe_n_out)
      else $error("transceiver drive differs from lane strobes");
   a_early_write: assert property ($fell(&cas_n_out) && xcvr_out.latch_a_to_b |-> $stable(lane_write_strobe_n_out) && $past(xcvr_out.latch_a_to_b))
      else $error("cas fell before lane strobes");
   a_col_setup: assert property ($fell(&cas_n_out) && !refresh_ack_out |-> $past(mux_col_sel_out) && $stable(dram_addr_out))
      else $error("column address not set a cycle before cas");
   a_row_setup: assert property ($fell(&ras_n_out) && !refresh_ack_out |-> !mux_col_sel_out && !$past(mux_col_sel_out) && $stable(dram_addr_out))
      else $error("row address not set a cycle before ras");
   a_one_bank: assert property (ras_n_out != 4'hf && !refresh_ack_out |-> $onehot(~ras_n_out))
      else $error("more than one bank strobed");
   a_held_cas_off: assert property (row_held_flag_out && !cycle_active_out && !refresh_ack_out |-> cas_n_out == 4'hf)
      else $error("cas active while row held idle");
   a_read_resp: assert property ($fell(read_complete_enable_n_out) |-> !ack_n_out ##1 (ack_n_out && read_complete_enable_n_out))
      else $error("read response not a one cycle pulse with ack");
   a_latch_on_cas: assert property ($rose(xcvr_out.latch_b_to_a) |-> $rose(&cas_n_out) && !$past(xcvr_out.chip_sel_b_to_a_n))
      else $error("read latch not at cas removal");
   a_delayed_copy: assert property ($rose(cycle_active_out) |=> cycle_active_delayed_out)
      else $error("delayed cycle flag late");
   a_ref_pulse: assert property (refresh_req_out |=> !refresh_req_out)
      else $error("refresh request longer than one cycle");
   a_ref_strobes: assert property ($rose(refresh_ack_out) |-> ##[1:2] (cas_n_out == 4'h0))
      else $error("refresh without cas on all banks");
endmodule : drc_ctrl_checker

bind drc_ctrl drc_ctrl_checker #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) chk (.ref_clk_in(ref_clk_in),
   .reset_in(reset_in), .ack_n_out(ack_n_out), .read_complete_enable_n_out(read_complete_enable_n_out),
   .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .mux_col_sel_out(mux_col_sel_out), .dram_addr_out(dram_addr_out),
   .lane_write_strobe_n_out(lane_write_strobe_n_out), .xcvr_out(xcvr_out), .cycle_active_out(cycle_active_out),
   .cycle_active_delayed_out(cycle_active_delayed_out), .row_held_flag_out(row_held_flag_out),
   .refresh_ack_out(refresh_ack_out), .refresh_req_out(refresh_req_out));

//--- drc_dram_model.sv
// Behavioural DRAM bank group answering reads with an address-derived word
`timescale 1ns/1ns
module drc_dram_model (
   // DRAM pins
   input wire logic [3:0] ras_n_in,
   input wire logic [3:0] cas_n_in,
   input wire logic [8:0] addr_in,
   output logic [31:0] data_out
);
   logic [1:0] bank_reg;
   logic [8:0] row_reg;
   logic [31:0] word;
   // Row is latched as a single bank's strobe falls; refresh strobes all banks and is ignored
   always @(ras_n_in) begin
      if ($onehot(~ras_n_in)) begin
         bank_reg = ras_n_in[1] ? (ras_n_in[2] ? 2'h3 : 2'h2) : 2'h1;
         if (!ras_n_in[0]) bank_reg = 2'h0;
         row_reg = addr_in;
      end
   end
   assign word = {bank_reg, 3'h5, row_reg, 9'h0, addr_in};
   // Outputs off: show the inverse so a stale capture cannot pass
   assign data_out = (cas_n_in != 4'hf) ? word : ~word;
endmodule : drc_dram_model

//--- drc_ctrl_tb.sv
// Self-checking bench for the DRAM controller
`timescale 1ns/1ns
module drc_ctrl_tb
   import drc_pkg::*;
;
   logic ref_clk_in, reset_in, gate_n, ack_n, rdc_n, rd_valid, rd_ready, mux_col, cyc, cyc_d;
   logic row_held, rst_act, ref_ack, ref_req, gate_out, ref_seen;
   drc_req_s req;
   drc_xcvr_s xcvr;
   logic [31:0] rd_data, dram_data, lfsr;
   logic [3:0] ras_n, cas_n, lanes_n;
   logic [8:0] dram_addr;
   logic [20:0] a;
   logic [31:0] exp_q[$];
   int error_cnt = 0, n_compared = 0, cycles = 0, since_ref = -1, i, n;

   drc_ctrl #(.DATA_W(32), .FIFO_DEPTH(16)) uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cpu_req_in(req),
      .cpu_output_gate_n_in(gate_n), .ack_n_out(ack_n), .read_complete_enable_n_out(rdc_n), .rd_data_out(rd_data),
      .rd_data_valid_out(rd_valid), .rd_data_ready_in(rd_ready), .dram_data_in(dram_data), .ras_n_out(ras_n),
      .cas_n_out(cas_n), .mux_col_sel_out(mux_col), .dram_addr_out(dram_addr), .lane_write_strobe_n_out(lanes_n),
      .xcvr_out(xcvr), .drive_b_to_a_n_out(gate_out), .cycle_active_out(cyc), .cycle_active_delayed_out(cyc_d),
      .row_held_flag_out(row_held), .reset_active_out(rst_act), .refresh_ack_out(ref_ack),
      .refresh_req_out(ref_req));
   drc_dram_model dram (.ras_n_in(ras_n), .cas_n_in(cas_n), .addr_in(dram_addr), .data_out(dram_data));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   function automatic logic [31:0] exp_word(input logic [20:0] ad);
      return {ad[19:18], 3'h5, ad[17:9], 9'h0, ad[8:0]};
   endfunction : exp_word

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // Mode 0 plain, 1 refused while the FIFO is full, 2 outside the memory space
   task automatic access(input logic rd, input logic [20:0] ad, input logic [3:0] be_n, input logic near,
         input int mode);
      int k;
      logic got;
      got = 0;
      ref_seen = 0;
      req <= '{rd_n: !rd, wr_n: rd, same_page_hint_n: !near, lane_enable_n: be_n, addr: ad};
      for (k = 0; k < 40 && mode != 0; k++) begin
         @(posedge ref_clk_in);
         if (ack_n === 1'b0) got = 1;
      end
      if (mode != 0) check(32'(got), 32'h0);
      if (mode == 1) rd_ready <= 1'b1;
      for (k = 0; k < 60 && mode != 2 && ack_n !== 1'b0; k++) @(posedge ref_clk_in);
      if (mode != 2) check(32'(ack_n), 32'h0);
      if (rd && mode != 2) begin
         check(32'(rdc_n), 32'h0);
         check(32'(ras_n), 32'(4'(~(4'h1 << ad[19:18]))));
         check(32'(xcvr.chip_sel_b_to_a_n), 32'h0);
         exp_q.push_back(exp_word(ad));
         gate_n <= 1'b0;
      end else if (mode != 2) begin
         check(32'(lanes_n), 32'(be_n));
         check(32'({xcvr.latch_a_to_b, xcvr.drive_a_to_b_n}), 32'({1'b1, be_n}));
      end
      req.rd_n <= 1'b1;
      req.wr_n <= 1'b1;
      @(posedge ref_clk_in);
      if (rd && mode != 2) check(32'(gate_out), 32'h0);
      gate_n <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      if (!rd && !ref_seen) begin
         check(32'({row_held, cas_n, ras_n}), 32'({1'b1, 4'hf, ~(4'h1 << ad[19:18])}));
      end
   endtask : access

   // ----------------------------------------
   // Clock, timeout and monitors
   // ----------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
      if (ref_req === 1'b1 || ref_ack === 1'b1) ref_seen = 1;
      if (ref_ack === 1'b1) since_ref <= 0;
      else if (since_ref >= 0) since_ref <= since_ref + 1;
      if (ref_req === 1'b1 && since_ref >= 0) check(32'(since_ref >= 1190 && since_ref <= 1210), 32'h1);
      if (rd_ready && rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset_in = 1'b1;
      req = '{rd_n: 1'b1, wr_n: 1'b1, same_page_hint_n: 1'b1, lane_enable_n: 4'hf, addr: 21'h0};
      gate_n = 1'b1;
      rd_ready = 1'b0;
      ref_seen = 0;
      lfsr = 32'h1d;
      repeat (6) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      for (n = 0; n < 200 && rst_act !== 1'b0; n++) @(posedge ref_clk_in);
      check(32'({rst_act, ref_seen}), 32'h1);
      for (i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         a = {1'b0, 2'(i), lfsr[17:0]};
         access(1'b0, a, lfsr[21:18], 1'b0, 0);
         access(1'b0, a ^ 21'h1, ~lfsr[21:18], 1'b1, 0);
      end
      for (i = 0; i < 16; i++) begin
         lfsr = next_rand(lfsr);
         access(1'b1, {1'b0, lfsr[19:0]}, 4'hf, 1'b0, 0);
      end
      lfsr = next_rand(lfsr);
      access(1'b1, {1'b0, lfsr[19:0]}, 4'hf, 1'b0, 1);
      for (n = 0; n < 200 && rd_valid !== 1'b0; n++) @(posedge ref_clk_in);
      check(32'(exp_q.size()), 32'h0);
      access(1'b1, 21'h1fffff, 4'hf, 1'b0, 2);
      access(1'b0, 21'h0c0000, 4'h0, 1'b0, 0);
      access(1'b1, 21'h0fffff, 4'hf, 1'b0, 0);
      repeat (2600) @(posedge ref_clk_in);
      check(32'(exp_q.size()), 32'h0);
      finish_test();
   end
endmodule : drc_ctrl_tb
